// >>> hw/sys_integration.sv
// sys_integration: interrupt status, reset cause, break handling and
// wait/stop sequencing of a small 8-bit controller, apb register access.
// assumes cpu, peripherals and reset sources are logic on the same clock,
// and that the quadruple-rate bus clock is this clock.
//
// Operation
// - pending flag reads 1 while its source requests, else 0
// - first status register: flags one..six in bits 7..2, bits 1..0 zero
// - any reset source wins over power state, break mode and cpu strobes, no arbitration among them
// - break request forces the cpu to the software interrupt vector
// - in break, peripheral flag clears blocked unless clear enable set
// - flag cleared in break stays cleared after break ends
// - two-step clears stay blocked in break; second step after break clears
// - wait or stop instruction clears the global interrupt mask
// - wait stops cpu clocks, peripheral clocks keep running
// - interrupt wake from wait starts stacking one cycle later
// - reset or break ends wait; break in wait sets stop/wait bit
// - watchdog enabled and running in wait when its disable bit is 0
// - stop resets system counter, gates clocks; irq, reset, break exit
// - stacking after interrupt stop exit waits for full recovery time
// - stop gates both clocks; double-rate stays if oscillator-in-stop set
// - stop recovery 4096 quad-rate cycles, 32 with short recovery bit
// - system counter held in reset during stop, then times recovery
// - reading reset cause register clears its flags afterwards
// - power-on reset sets power-on flag, clears all others
// - other reset sources set only their own flag
// - flags for pin, watchdog, illegal opcode, illegal address, low voltage
// - monitor-entry flag set when reset vector bytes erased, irq not at test
`timescale 1ns/1ps

module sys_integration
    import sys_integration_pkg::*;
#(
    parameter int REC_LONG  = STOP_REC_LONG_CYCLES,
    parameter int REC_SHORT = STOP_REC_SHORT_CYCLES
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // interrupt and reset sources
    input  wire logic [NUM_IRQ_SOURCES-1:0] irqPending,
    input  wire logic                       irqWake,
    input  wire resetReq_t                  resetReq,
    input  wire logic                       vectorCheck,
    input  wire logic [7:0]                 vectorHigh,
    input  wire logic [7:0]                 vectorLow,
    input  wire logic                       irqAtTestVoltage,
    // cpu and break module
    input  wire logic                       breakIrq,
    input  wire logic                       breakExit,
    input  wire logic                       waitInstr,
    input  wire logic                       stopInstr,
    output logic                            systemReset,
    output logic                            forceSwiVector,
    output logic                            clearIMask,
    output logic                            startStacking,
    output logic                            breakMode,
    output logic                            flagClearAllow,
    output logic                            watchdogEnable,
    output clockGate_t                      clockGate
);

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    logic        setupPhase;
    logic        accessDone;
    logic        wrLane0;
    logic [7:0]  rdSel;
    logic        mapped;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic [7:0]  rdAddr_r;

    logic [7:0]  intStatus1_r;
    logic [7:0]  intStatus2_r;
    logic [7:0]  intStatus3_r;
    logic [7:0]  resetCause_r;
    logic [7:0]  resetCause_nxt;
    logic [7:0]  breakFlagCtl_r;
    logic [7:0]  configOne_r;
    logic [7:0]  breakStatus_r;
    logic        breakMode_r;
    powerState_t pwrState_r;
    logic [12:0] sysCounter_r;
    logic        wakeByBreak_r;
    logic        monitorPending_r;

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready_r;
    assign wrLane0    = accessDone && pwrite && pstrb[0];

    // read mux and address check
    always_comb begin
        mapped = 1'b1;
        case (paddr)
            OFS_INT_STATUS_1:   rdSel = intStatus1_r;
            OFS_INT_STATUS_2:   rdSel = intStatus2_r;
            OFS_INT_STATUS_3:   rdSel = intStatus3_r;
            OFS_RESET_CAUSE:    rdSel = resetCause_r;
            OFS_BREAK_FLAG_CTL: rdSel = breakFlagCtl_r;
            OFS_CONFIG_ONE:     rdSel = configOne_r;
            OFS_BREAK_STATUS:   rdSel = breakStatus_r;
            OFS_POWER_STATUS:   rdSel = {5'h00, breakMode_r, pwrState_r};
            default: begin
                rdSel  = 8'h00;
                mapped = 1'b0;
            end
        endcase
    end

    // one wait-free access: answer set up during the setup cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            rdAddr_r  <= 8'h00;
        end else if (setupPhase) begin
            pready_r  <= 1'b1;
            prdata_r  <= pwrite ? 32'h0000_0000 : {24'h000000, rdSel};
            pslverr_r <= !mapped;
            rdAddr_r  <= pwrite ? 8'hff : paddr;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt pending status

    always_ff @(posedge clock) begin
        if (rst) begin
            intStatus1_r <= 8'h00;
            intStatus2_r <= 8'h00;
            intStatus3_r <= 8'h00;
        end else begin
            intStatus1_r <= {irqPending[5:0], 2'b00};
            intStatus2_r <= irqPending[13:6];
            intStatus3_r <= irqPending[21:14];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset sources and cause flags

    logic monitorReset;
    logic anyReset;

    assign monitorReset = monitorPending_r && vectorCheck && !irqAtTestVoltage
                          && (vectorHigh == ERASED_BYTE) && (vectorLow == ERASED_BYTE);
    assign anyReset = (|resetReq) || monitorReset;

    // monitor entry check armed once per power-on
    always_ff @(posedge clock) begin
        if (rst) begin
            monitorPending_r <= 1'b1;
        end else if (vectorCheck) begin
            monitorPending_r <= 1'b0;
        end
    end

    // cause flags: read clears what was read, new sets win
    always_comb begin
        resetCause_nxt = resetCause_r;
        if (accessDone && !pwrite && rdAddr_r == OFS_RESET_CAUSE) begin
            resetCause_nxt = resetCause_r & ~prdata_r[7:0];
        end
        resetCause_nxt[RC_PIN]        = resetCause_nxt[RC_PIN] | resetReq.pin;
        resetCause_nxt[RC_WATCHDOG]   = resetCause_nxt[RC_WATCHDOG] | resetReq.watchdog;
        resetCause_nxt[RC_ILL_OPCODE] = resetCause_nxt[RC_ILL_OPCODE] | resetReq.illOpcode;
        resetCause_nxt[RC_ILL_ADDR]   = resetCause_nxt[RC_ILL_ADDR] | resetReq.illAddress;
        resetCause_nxt[RC_LOW_VOLT]   = resetCause_nxt[RC_LOW_VOLT] | resetReq.lowVoltage;
        resetCause_nxt[RC_MONITOR]    = resetCause_nxt[RC_MONITOR] | monitorReset;
    end

    // power-on leaves only its own flag
    always_ff @(posedge clock) begin
        if (rst) begin
            resetCause_r <= RESET_CAUSE_RST;
        end else begin
            resetCause_r <= resetCause_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software control registers

    // break flag control and configuration, lane 0 only
    always_ff @(posedge clock) begin
        if (rst) begin
            breakFlagCtl_r <= BREAK_FLAG_CTL_RST;
            configOne_r    <= CONFIG_ONE_RST;
        end else if (wrLane0) begin
            if (paddr == OFS_BREAK_FLAG_CTL) begin
                breakFlagCtl_r <= {pwdata[BFC_CLEAR_ENABLE], 7'h00};
            end
            if (paddr == OFS_CONFIG_ONE) begin
                configOne_r <= {5'h00, pwdata[2:0]};
            end
        end
    end

    logic breakDuringLowPower;
    assign breakDuringLowPower = breakIrq && (pwrState_r == PWR_WAIT || pwrState_r == PWR_STOP);

    // break status: hardware sets, writing 0 clears, set wins
    always_ff @(posedge clock) begin
        if (rst) begin
            breakStatus_r <= 8'h00;
        end else begin
            if (breakDuringLowPower) begin
                breakStatus_r[BST_STOP_WAIT] <= 1'b1;
            end else if (wrLane0 && paddr == OFS_BREAK_STATUS && !pwdata[BST_STOP_WAIT]) begin
                breakStatus_r[BST_STOP_WAIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // break state and flag protection

    // break mode held from the break request until the break exit or any reset
    always_ff @(posedge clock) begin
        if (rst || anyReset) begin
            breakMode_r <= 1'b0;
        end else if (breakIrq) begin
            breakMode_r <= 1'b1;
        end else if (breakExit) begin
            breakMode_r <= 1'b0;
        end
    end

    // second step gated by same level
    always_ff @(posedge clock) begin
        if (rst) begin
            flagClearAllow <= 1'b1;
        end else begin
            flagClearAllow <= !(breakMode_r || breakIrq) || breakFlagCtl_r[BFC_CLEAR_ENABLE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low-power sequencing

    logic [12:0] recLength;
    logic        recDone;

    assign recLength = configOne_r[CFG_SHORT_STOP_REC] ? 13'(REC_SHORT) : 13'(REC_LONG);
    assign recDone   = (sysCounter_r >= recLength - 13'd1);

    // power state: reset beats every other exit
    always_ff @(posedge clock) begin
        if (rst) begin
            pwrState_r    <= PWR_RUN;
            wakeByBreak_r <= 1'b0;
        end else if (anyReset) begin
            pwrState_r <= PWR_RUN;
        end else begin
            case (pwrState_r)
                PWR_RUN: begin
                    if (stopInstr) begin
                        pwrState_r <= PWR_STOP;
                    end else if (waitInstr) begin
                        pwrState_r <= PWR_WAIT;
                    end
                end
                PWR_WAIT: begin
                    if (breakIrq || irqWake) begin
                        pwrState_r <= PWR_RUN;
                    end
                end
                PWR_STOP: begin
                    if (breakIrq || irqWake) begin
                        pwrState_r    <= PWR_RECOVER;
                        wakeByBreak_r <= breakIrq;
                    end
                end
                PWR_RECOVER: begin
                    if (recDone) begin
                        pwrState_r <= PWR_RUN;
                    end
                end
                default: pwrState_r <= PWR_RUN;
            endcase
        end
    end

    // counter held until recovery, then times it
    always_ff @(posedge clock) begin
        if (rst || pwrState_r != PWR_RECOVER) begin
            sysCounter_r <= 13'h0000;
        end else begin
            sysCounter_r <= sysCounter_r + 13'd1;
        end
    end

    // cpu event strobes
    always_ff @(posedge clock) begin
        if (rst) begin
            systemReset    <= 1'b0;
            forceSwiVector <= 1'b0;
            clearIMask     <= 1'b0;
            startStacking  <= 1'b0;
        end else begin
            systemReset <= anyReset;
            clearIMask  <= !anyReset && pwrState_r == PWR_RUN && (waitInstr || stopInstr);
            forceSwiVector <= !anyReset && ((breakIrq && pwrState_r != PWR_STOP)
                              || (pwrState_r == PWR_RECOVER && recDone && wakeByBreak_r));
            startStacking <= !anyReset && ((pwrState_r == PWR_WAIT && irqWake && !breakIrq)
                             || (pwrState_r == PWR_RECOVER && recDone && !wakeByBreak_r));
        end
    end

    // clock gates follow the registered power state, one cycle behind it
    always_ff @(posedge clock) begin
        if (rst) begin
            clockGate <= '{cpu: 1'b1, periph: 1'b1, doubleRate: 1'b1, quadRate: 1'b1};
        end else begin
            case (pwrState_r)
                PWR_WAIT: clockGate <= '{cpu: 1'b0, periph: 1'b1, doubleRate: 1'b1, quadRate: 1'b1};
                PWR_STOP: clockGate <= '{cpu: 1'b0, periph: 1'b0,
                                         doubleRate: configOne_r[CFG_OSC_IN_STOP], quadRate: 1'b0};
                PWR_RECOVER: clockGate <= '{cpu: 1'b0, periph: 1'b0, doubleRate: 1'b1, quadRate: 1'b1};
                default: clockGate <= '{cpu: 1'b1, periph: 1'b1, doubleRate: 1'b1, quadRate: 1'b1};
            endcase
        end
    end

    // watchdog runs unless disabled, wait included
    always_ff @(posedge clock) begin
        if (rst) begin
            watchdogEnable <= 1'b1;
        end else begin
            watchdogEnable <= !configOne_r[CFG_WATCHDOG_DIS];
        end
    end

    assign pready    = pready_r;
    assign prdata    = prdata_r;
    assign pslverr   = pslverr_r;
    assign breakMode = breakMode_r;

endmodule

// >>> hw/sys_integration_pkg.sv
// sys_integration_pkg: register map, field positions, reset values and
// carrier types shared by the system integration logic.
// assumes a 32-bit apb bus with one aligned word per register.
package sys_integration_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_INT_STATUS_1   = 8'h00;
    localparam logic [7:0] OFS_INT_STATUS_2   = 8'h04;
    localparam logic [7:0] OFS_INT_STATUS_3   = 8'h08;
    localparam logic [7:0] OFS_RESET_CAUSE    = 8'h0c;
    localparam logic [7:0] OFS_BREAK_FLAG_CTL = 8'h10;
    localparam logic [7:0] OFS_CONFIG_ONE     = 8'h14;
    localparam logic [7:0] OFS_BREAK_STATUS   = 8'h18;
    localparam logic [7:0] OFS_POWER_STATUS   = 8'h1c;

    // reset cause field positions
    localparam int RC_POWER_ON   = 7;
    localparam int RC_PIN        = 6;
    localparam int RC_WATCHDOG   = 5;
    localparam int RC_ILL_OPCODE = 4;
    localparam int RC_ILL_ADDR   = 3;
    localparam int RC_MONITOR    = 2;
    localparam int RC_LOW_VOLT   = 1;

    // control field positions
    localparam int BFC_CLEAR_ENABLE    = 7;
    localparam int CFG_WATCHDOG_DIS    = 0;
    localparam int CFG_SHORT_STOP_REC  = 1;
    localparam int CFG_OSC_IN_STOP     = 2;
    localparam int BST_STOP_WAIT       = 1;

    // values after reset
    localparam logic [7:0] RESET_CAUSE_RST    = 8'h80;
    localparam logic [7:0] BREAK_FLAG_CTL_RST = 8'h00;
    localparam logic [7:0] CONFIG_ONE_RST     = 8'h00;

    // stop recovery lengths in quadruple-rate bus clock cycles
    localparam int STOP_REC_LONG_CYCLES  = 4096;
    localparam int STOP_REC_SHORT_CYCLES = 32;

    localparam int NUM_IRQ_SOURCES = 22;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // non-power-on reset requests, one bit per source
    typedef struct packed {
        logic pin;
        logic watchdog;
        logic illOpcode;
        logic illAddress;
        logic lowVoltage;
    } resetReq_t;

    // clock gating towards the clock generator
    typedef struct packed {
        logic cpu;
        logic periph;
        logic doubleRate;
        logic quadRate;
    } clockGate_t;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_WAIT,
        PWR_STOP,
        PWR_RECOVER
    } powerState_t;

endpackage

// >>> verification/sys_integration_asserts.sv
// sys_integration_asserts: port-level checks for the system integration block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
module sys_integration_asserts
    import sys_integration_pkg::*;
#(
    parameter int REC_LONG  = STOP_REC_LONG_CYCLES,
    parameter int REC_SHORT = STOP_REC_SHORT_CYCLES
) (
    input logic                       clock,
    input logic                       rst,
    input logic                       psel,
    input logic                       penable,
    input logic                       pwrite,
    input logic [7:0]                 paddr,
    input logic                       pready,
    input logic [31:0]                prdata,
    input logic [NUM_IRQ_SOURCES-1:0] irqPending,
    input logic                       irqWake,
    input resetReq_t                  resetReq,
    input logic                       breakIrq,
    input logic                       waitInstr,
    input logic                       stopInstr,
    input logic                       systemReset,
    input logic                       forceSwiVector,
    input logic                       clearIMask,
    input logic                       startStacking,
    input logic                       breakMode,
    input logic                       flagClearAllow,
    input clockGate_t                 clockGate
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    logic        quiet;
    logic [15:0] recCnt_r;

    // no reset or break request
    assign quiet = (resetReq == '0) && !breakIrq;

    // recovery gating length
    always_ff @(posedge clock) begin
        if (rst || clockGate != 4'b0011)
            recCnt_r <= '0;
        else
            recCnt_r <= recCnt_r + 16'h1;
    end

    ////////////////////////////////////////
    chk_ready_pulse: assert property (
        psel && !penable |=> pready ##1 !pready) else $error("pready width");
    chk_status_map: assert property (
        psel && !penable && !pwrite && paddr == 8'h00
        |=> prdata[7:0] == {$past(irqPending[5:0], 2), 2'b00}) else $error("status 1 read");
    chk_mask_clear: assert property (
        (waitInstr || stopInstr) && clockGate.cpu && quiet && !irqWake
        |=> clearIMask) else $error("mask not cleared");
    chk_wait_gate: assert property (
        waitInstr && !stopInstr && clockGate.cpu && quiet && !irqWake
        |=> ##1 !clockGate.cpu && clockGate.periph) else $error("wait gating");
    chk_wake_stack: assert property (
        irqWake && !clockGate.cpu && clockGate.periph && quiet && !startStacking
        |=> startStacking) else $error("wait wake late");
    chk_stop_gate: assert property (
        stopInstr && clockGate.cpu && quiet && !irqWake
        |=> ##1 !clockGate.cpu && !clockGate.periph && !clockGate.quadRate) else $error("stop gating");
    chk_rec_early: assert property (
        startStacking && clockGate == 4'b0011
        |-> recCnt_r >= 16'(REC_SHORT - 3)) else $error("early stacking");
    chk_rec_bound: assert property (
        clockGate == 4'b0011 |-> recCnt_r <= 16'(REC_LONG + 3)) else $error("recovery too long");
    chk_reset_first: assert property (
        resetReq != '0
        |=> systemReset && !startStacking && !forceSwiVector && !clearIMask) else $error("reset not first");
    chk_break_swi: assert property (
        $rose(breakIrq) && !breakMode && clockGate.periph && resetReq == '0
        |=> forceSwiVector) else $error("break not vectored");
    chk_clear_allow: assert property (
        !breakMode && !breakIrq |=> flagClearAllow) else $error("clear blocked");

    // main scenarios reached
    cov_stack: cover property (startStacking);
    cov_swi: cover property (forceSwiVector);
    cov_reset: cover property (systemReset);
endmodule

bind sys_integration sys_integration_asserts #(
    .REC_LONG (REC_LONG),
    .REC_SHORT(REC_SHORT)
) chkInst (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
    .irqPending, .irqWake, .resetReq, .breakIrq, .waitInstr, .stopInstr,
    .systemReset, .forceSwiVector, .clearIMask, .startStacking, .breakMode,
    .flagClearAllow, .clockGate
);

// >>> verification/cpu_periph_model.sv
// cpu_periph_model: cpu side issuing wait/stop, wakes and breaks
// assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
module cpu_periph_model (
    input  wire logic clock,
    input  wire logic clearIMask,
    input  wire logic startStacking,
    input  wire logic forceSwiVector,
    output logic      waitInstr = 1'b0,
    output logic      stopInstr = 1'b0,
    output logic      irqWake   = 1'b0,
    output logic      breakIrq  = 1'b0,
    output logic      breakExit = 1'b0
);
    int nMask = 0;

    // counts mask-clear strobes
    always @(posedge clock)
        if (clearIMask === 1'b1) nMask <= nMask + 1;

    // wait or stop pulse
    task automatic instr(input logic stop);
        waitInstr <= !stop;
        stopInstr <= stop;
        @(posedge clock);
        waitInstr <= 1'b0;
        stopInstr <= 1'b0;
    endtask

    // wake or break, edges to answer
    task automatic wake(input logic brk, output int n);
        n = 0;
        irqWake  <= !brk;
        breakIrq <= brk;
        do begin
            @(posedge clock);
            n++;
            breakIrq <= 1'b0;
        end while ((brk ? forceSwiVector : startStacking) !== 1'b1 && n < 5000);
        irqWake <= 1'b0;
    endtask

    // leave break state
    task automatic leaveBreak;
        breakExit <= 1'b1;
        @(posedge clock);
        breakExit <= 1'b0;
    endtask
endmodule

// >>> verification/sys_integration_tb.sv
// sys_integration_tb: directed scenarios over apb and the cpu side
// assumes the cpu model and the bound checker
`timescale 1ns/1ps
module sys_integration_tb
    import sys_integration_pkg::*;
();
    localparam int          REC_L = 64, REC_S = 32;
    localparam logic [21:0] PAT   = 22'h2a5c3f;

    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, vectorHigh = 8'hff, vectorLow = 8'hff;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        pready, pslverr, erv, vectorCheck = 1'b0, irqAtTestVoltage = 1'b0;
    logic [21:0] irqPending = '0;
    resetReq_t   resetReq = '0;
    logic        irqWake, breakIrq, breakExit, waitInstr, stopInstr;
    logic        systemReset, forceSwiVector, clearIMask, startStacking;
    logic        breakMode, flagClearAllow, watchdogEnable;
    clockGate_t  clockGate;
    int          errTotal = 0, nCompared = 0;
    int          rcBit [5] = '{RC_LOW_VOLT, RC_ILL_ADDR, RC_ILL_OPCODE, RC_WATCHDOG, RC_PIN};

    sys_integration #(.REC_LONG(REC_L), .REC_SHORT(REC_S)) dut (
        .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
        .pready, .prdata, .pslverr, .irqPending, .irqWake, .resetReq, .vectorCheck,
        .vectorHigh, .vectorLow, .irqAtTestVoltage, .breakIrq,
        .breakExit, .waitInstr, .stopInstr, .systemReset, .forceSwiVector, .clearIMask,
        .startStacking, .breakMode, .flagClearAllow, .watchdogEnable, .clockGate
    );
    cpu_periph_model cpu (
        .clock, .clearIMask, .startStacking, .forceSwiVector,
        .waitInstr, .stopInstr, .irqWake, .breakIrq, .breakExit
    );

    ////////////////////////////////////////
    initial begin
        forever #2.5 clock = ~clock;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) errTotal++;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, rdv, erv);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, rdv, erv);
        check($sformatf("reg %h", a), rdv, {24'h0, e});
    endtask

    ////////////////////////////////////////
    // reset cause flags, monitor entry, reset out of stop
    task automatic t_cause;
        rdchk(OFS_RESET_CAUSE, 8'h80); // power-on value
        rdchk(OFS_RESET_CAUSE, 8'h00); // cleared by read
        vectorCheck <= 1'b1;
        @(posedge clock);
        vectorCheck <= 1'b0;
        cyc(2);
        rdchk(OFS_RESET_CAUSE, 8'h04); // monitor flag
        for (int i = 0; i < 5; i++) begin
            resetReq <= resetReq_t'(5'h1 << i);
            @(posedge clock);
            resetReq <= '0;
            cyc(2);
            rdchk(OFS_RESET_CAUSE, 8'h1 << rcBit[i]); // own flag
        end
        cpu.instr(1'b1);
        cyc(3);
        check("stopGate", clockGate, 4'b0000); // clocks off
        resetReq <= 5'h10;
        @(posedge clock);
        resetReq <= 5'h01;
        @(posedge clock);
        resetReq <= 5'h00;
        cyc(3);
        check("runGate", clockGate, 4'b1111); // reset exit
        rdchk(OFS_RESET_CAUSE, 8'h42); // flags accumulate
    endtask

    // pending flags and read-only status
    task automatic t_irq;
        irqPending <= PAT;
        cyc(3);
        rdchk(OFS_INT_STATUS_1, {PAT[5:0], 2'b00}); // low zero
        rdchk(OFS_INT_STATUS_2, PAT[13:6]); // flags seen
        rdchk(OFS_INT_STATUS_3, PAT[21:14]); // flags seen
        for (int a = 0; a < 12; a += 4) wr(8'(a), 8'hff);
        rdchk(OFS_INT_STATUS_1, {PAT[5:0], 2'b00}); // write ignored
        rdchk(OFS_INT_STATUS_2, PAT[13:6]); // write ignored
        apb(1'b0, 8'h40, 32'h0, rdv, erv);
        check("unmapped", erv, 1'b1); // refused access
        irqPending <= '0;
        cyc(3);
        rdchk(OFS_INT_STATUS_3, 8'h00); // no request
    endtask

    // wait entry, wake, break and flag protection
    task automatic t_wait;
        int m, n;
        m = cpu.nMask;
        cpu.instr(1'b0);
        cyc(3);
        check("maskClr", cpu.nMask - m, 1); // mask cleared
        check("waitGate", clockGate, 4'b0111); // cpu clock off
        check("wdog", watchdogEnable, 1'b1); // watchdog runs
        cpu.wake(1'b0, n);
        check("wakeLat", n, 2); // stacking delay
        cpu.instr(1'b0);
        cyc(3);
        cpu.wake(1'b1, n);
        check("brkLat", n, 2); // break exit
        rdchk(OFS_BREAK_STATUS, 8'h02); // stop/wait bit
        check("brkMode", breakMode, 1'b1); // break state
        check("protect", flagClearAllow, 1'b0); // flags held
        wr(OFS_BREAK_FLAG_CTL, 8'h80);
        cyc(2);
        check("clrEn", flagClearAllow, 1'b1); // clear enabled
        wr(OFS_BREAK_FLAG_CTL, 8'h00);
        cyc(2);
        check("protect2", flagClearAllow, 1'b0); // two-step held
        cpu.leaveBreak();
        cyc(2);
        check("brkOff", breakMode, 1'b0); // break left
        check("allow", flagClearAllow, 1'b1); // clears resume
    endtask

    // stop entry gating and recovery length
    task automatic t_stop(input logic [7:0] cfg, input int rec);
        int n;
        wr(OFS_CONFIG_ONE, cfg);
        cpu.instr(1'b1);
        cyc(3);
        check("stopGate", clockGate, {2'b00, cfg[CFG_OSC_IN_STOP], 1'b0}); // gating
        cpu.wake(1'b0, n);
        check("recLen", n, rec + 2); // recovery
        cyc(3);
    endtask

    ////////////////////////////////////////
    task automatic final_report;
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // hang guard
    initial begin
        #50000;
        errTotal++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_cause();
        t_irq();
        t_wait();
        t_stop(8'h06, REC_S);
        t_stop(8'h00, REC_L);
        final_report();
    end
endmodule
